/* hdl/trc_pkg.sv */
/*
  Shared constants and types for the timer reload and input capture block:
  register offsets, field positions, reset values, clock select codes and
  the register request struct.
  Assumes an 8-bit register port with byte offsets as given below.
*/
package trc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRE_W  = 10;
  localparam int unsigned WIDE_W = 16;
  localparam int unsigned IRQ_W  = 3;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } trc_bus_req_s;

  // index 0 is counter a, index 1 is counter b
  localparam logic [1:0][ADDR_W-1:0] OFF_CNT_RELOAD = {8'h23, 8'h31};
  localparam logic [1:0][ADDR_W-1:0] OFF_CNT_VALUE  = {8'h24, 8'h32};
  localparam logic [1:0][ADDR_W-1:0] OFF_CNT_CTRL   = {8'h25, 8'h33};
  localparam logic [ADDR_W-1:0] OFF_WIDE_CTRL = 8'h2E;
  localparam logic [ADDR_W-1:0] OFF_CAP_LO    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CAP_HI    = 8'h29;
  localparam logic [ADDR_W-1:0] OFF_WCNT_LO   = 8'h2A;
  localparam logic [ADDR_W-1:0] OFF_WCNT_HI   = 8'h2B;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h39;

  localparam logic [DATA_W-1:0] RST_RELOAD    = 8'h00;
  localparam logic [DATA_W-1:0] RST_CNT       = 8'h00;
  localparam logic [DATA_W-1:0] RST_CTRL      = 8'h00;
  localparam logic [WIDE_W-1:0] RST_WIDE      = 16'h0000;
  localparam logic [PRE_W-1:0]  RST_PRE       = 10'h000;
  localparam logic [IRQ_W-1:0]  RST_IRQ       = 3'h0;
  localparam logic [DATA_W-1:0] CNT_TOP       = 8'hFF;
  localparam logic [DATA_W-1:0] CNT_STEP      = 8'h01;
  localparam logic [WIDE_W-1:0] WIDE_STEP     = 16'h0001;

  localparam int unsigned BIT_FLT_EN   = 7;
  localparam int unsigned BIT_EDGE_SEL = 6;
  localparam int unsigned CS_MSB       = 2;
  localparam int unsigned FLT_SAMPLES  = 4;

  localparam int unsigned IRQ_OVF_A = 0;
  localparam int unsigned IRQ_OVF_B = 1;
  localparam int unsigned IRQ_CAP   = 2;

  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

endpackage

/* hdl/trc_timer.sv */
/*
  Two 8-bit up counters with overflow reload, a 16-bit counter with input
  capture (edge select, optional four-sample noise filter), interrupt
  status/mask and the register port.
  Assumes all inputs synchronous to mclk and a master that never issues
  read and write strobes together.
*/
// Local design decision: the strobed register port.
// Operation
// - reload register is 8-bit, read/write, resets zero
// - overflow loads counter from its reload register
// - counters count up, writable, resume next cycle
// - filter bit 7; off captures first edge
// - filter needs four equal samples of level
// - filter samples every cpu clock cycle
// - edge bit 6 zero captures on falling
// - edge bit one captures on rising edge
`timescale 1ns/1ps
module trc_timer
  import trc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire trc_bus_req_s      reg_req,
  output logic [DATA_W-1:0]      reg_rdata,
  input  wire logic              capture_input_pin,
  input  wire logic              count_a_pin,
  input  wire logic              count_b_pin,
  output logic                   irq
);

  function automatic logic clk_tick(input logic [2:0]       cs,
                                    input logic [PRE_W-1:0] pre,
                                    input logic             rise,
                                    input logic             fall);
    logic t;
    t = 1'b0;
    unique case (cs)
      CS_STOP:     t = 1'b0;
      CS_DIV1:     t = 1'b1;
      CS_DIV8:     t = &pre[2:0];
      CS_DIV64:    t = &pre[5:0];
      CS_DIV256:   t = &pre[7:0];
      CS_DIV1024:  t = &pre[9:0];
      CS_EXT_FALL: t = fall;
      CS_EXT_RISE: t = rise;
    endcase
    return t;
  endfunction

  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;

  assign wr    = reg_req.wr;
  assign rd    = reg_req.rd;
  assign addr  = reg_req.addr;
  assign wdata = reg_req.wdata;

  // ---------------- 8-bit counters ----------------
  logic [1:0][DATA_W-1:0] cnt_ff;
  logic [1:0][DATA_W-1:0] nxt_cnt;
  logic [1:0][DATA_W-1:0] reload_ff;
  logic [1:0][DATA_W-1:0] nxt_reload;
  logic [1:0][2:0]        cs_ff;
  logic [1:0][2:0]        nxt_cs;
  logic [1:0]             ext_ff;
  logic [1:0]             ext_in;
  logic [1:0]             tick;
  logic [1:0]             ovf;
  logic [PRE_W-1:0]       pre_ff;
  logic [PRE_W-1:0]       nxt_pre;

  assign ext_in = {count_b_pin, count_a_pin};

  always_comb begin
    nxt_pre    = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
    nxt_cnt    = cnt_ff;
    nxt_reload = reload_ff;
    nxt_cs     = cs_ff;
    tick       = 2'b00;
    ovf        = 2'b00;
    for (int i = 0; i < 2; i++) begin
      tick[i] = clk_tick(cs_ff[i], pre_ff, ext_in[i] & ~ext_ff[i],
                         ~ext_in[i] & ext_ff[i]);
      if (wr && addr == OFF_CNT_RELOAD[i]) begin
        nxt_reload[i] = wdata;
      end
      if (wr && addr == OFF_CNT_CTRL[i]) begin
        nxt_cs[i] = wdata[CS_MSB:0];
      end
      if (wr && addr == OFF_CNT_VALUE[i]) begin
        nxt_cnt[i] = wdata;
      end else if (tick[i]) begin
        if (cnt_ff[i] == CNT_TOP) begin
          nxt_cnt[i] = reload_ff[i];
          ovf[i]     = 1'b1;
        end else begin
          nxt_cnt[i] = cnt_ff[i] + CNT_STEP;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff    <= {2{RST_CNT}};
      reload_ff <= {2{RST_RELOAD}};
      cs_ff     <= {2{CS_STOP}};
      ext_ff    <= 2'b00;
      pre_ff    <= RST_PRE;
    end else begin
      cnt_ff    <= nxt_cnt;
      reload_ff <= nxt_reload;
      cs_ff     <= nxt_cs;
      ext_ff    <= ext_in;
      pre_ff    <= nxt_pre;
    end
  end

  // ---------------- 16-bit counter and capture ----------------
  logic              flt_en_ff;
  logic              nxt_flt_en;
  logic              edge_sel_ff;
  logic              nxt_edge_sel;
  logic [2:0]        wcs_ff;
  logic [2:0]        nxt_wcs;
  logic [WIDE_W-1:0] wcnt_ff;
  logic [WIDE_W-1:0] nxt_wcnt;
  logic [WIDE_W-1:0] cap_ff;
  logic [WIDE_W-1:0] nxt_cap;
  logic [FLT_SAMPLES-2:0] samp_ff;
  logic [FLT_SAMPLES-2:0] nxt_samp;
  logic              level_ff;
  logic              nxt_level;
  logic              primed_ff;
  logic              all_hi;
  logic              all_lo;
  logic              cap_evt;

  always_comb begin
    nxt_flt_en   = flt_en_ff;
    nxt_edge_sel = edge_sel_ff;
    nxt_wcs      = wcs_ff;
    if (wr && addr == OFF_WIDE_CTRL) begin
      nxt_flt_en   = wdata[BIT_FLT_EN];
      nxt_edge_sel = wdata[BIT_EDGE_SEL];
      nxt_wcs      = wdata[CS_MSB:0];
    end
    nxt_wcnt = wcnt_ff;
    if (clk_tick(wcs_ff, pre_ff, 1'b0, 1'b0)) begin
      nxt_wcnt = wcnt_ff + WIDE_STEP;
    end
    // sampled every cycle; pin plus three past samples
    nxt_samp = {samp_ff[FLT_SAMPLES-3:0], capture_input_pin};
    all_hi   = capture_input_pin & (&samp_ff);
    all_lo   = ~capture_input_pin & ~(|samp_ff);
    if (!primed_ff) begin
      nxt_level = capture_input_pin;
    end else if (flt_en_ff) begin
      if (all_hi) begin
        nxt_level = 1'b1;
      end else if (all_lo) begin
        nxt_level = 1'b0;
      end else begin
        nxt_level = level_ff;
      end
    end else begin
      nxt_level = capture_input_pin;
    end
    // edge select picks falling (0) or rising (1)
    cap_evt = primed_ff && (nxt_level != level_ff)
              && (nxt_level == edge_sel_ff);
    nxt_cap = cap_evt ? wcnt_ff : cap_ff;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flt_en_ff   <= 1'b0;
      edge_sel_ff <= 1'b0;
      wcs_ff      <= CS_STOP;
      wcnt_ff     <= RST_WIDE;
      cap_ff      <= RST_WIDE;
      samp_ff     <= '0;
      level_ff    <= 1'b0;
      primed_ff   <= 1'b0;
    end else begin
      flt_en_ff   <= nxt_flt_en;
      edge_sel_ff <= nxt_edge_sel;
      wcs_ff      <= nxt_wcs;
      wcnt_ff     <= nxt_wcnt;
      cap_ff      <= nxt_cap;
      samp_ff     <= nxt_samp;
      level_ff    <= nxt_level;
      primed_ff   <= 1'b1;
    end
  end

  // ---------------- interrupts and read port ----------------
  logic [IRQ_W-1:0]  stat_ff;
  logic [IRQ_W-1:0]  nxt_stat;
  logic [IRQ_W-1:0]  mask_ff;
  logic [IRQ_W-1:0]  nxt_mask;
  logic [IRQ_W-1:0]  evt;
  logic [DATA_W-1:0] hi_tmp_ff;
  logic [DATA_W-1:0] nxt_hi_tmp;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    evt = '0;
    evt[IRQ_OVF_A] = ovf[0];
    evt[IRQ_OVF_B] = ovf[1];
    evt[IRQ_CAP]   = cap_evt;
    // a new event in the clearing read cycle survives
    nxt_stat = ((rd && addr == OFF_IRQ_STAT) ? RST_IRQ : stat_ff) | evt;
    nxt_mask = (wr && addr == OFF_IRQ_MASK) ? wdata[IRQ_W-1:0] : mask_ff;
    nxt_hi_tmp = hi_tmp_ff;
    nxt_rdata  = '0;
    if (rd) begin
      for (int i = 0; i < 2; i++) begin
        if (addr == OFF_CNT_RELOAD[i]) nxt_rdata = reload_ff[i];
        if (addr == OFF_CNT_VALUE[i])  nxt_rdata = cnt_ff[i];
        if (addr == OFF_CNT_CTRL[i])   nxt_rdata = {5'h00, cs_ff[i]};
      end
      unique case (addr)
        OFF_WIDE_CTRL: nxt_rdata = {flt_en_ff, edge_sel_ff, 3'h0, wcs_ff};
        OFF_CAP_LO: begin
          nxt_rdata  = cap_ff[7:0];
          nxt_hi_tmp = cap_ff[15:8];
        end
        OFF_WCNT_LO: begin
          nxt_rdata  = wcnt_ff[7:0];
          nxt_hi_tmp = wcnt_ff[15:8];
        end
        OFF_CAP_HI:   nxt_rdata = hi_tmp_ff;
        OFF_WCNT_HI:  nxt_rdata = hi_tmp_ff;
        OFF_IRQ_STAT: nxt_rdata = {5'h00, stat_ff};
        OFF_IRQ_MASK: nxt_rdata = {5'h00, mask_ff};
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stat_ff   <= RST_IRQ;
      mask_ff   <= RST_IRQ;
      hi_tmp_ff <= 8'h00;
      rdata_ff  <= 8'h00;
    end else begin
      stat_ff   <= nxt_stat;
      mask_ff   <= nxt_mask;
      hi_tmp_ff <= nxt_hi_tmp;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = |(stat_ff & mask_ff);

  // ---------------- assertions ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_reload_write: assert property (
    wr && addr == OFF_CNT_RELOAD[1] |=> reload_ff[1] == $past(wdata))
    else $error("reload register did not take written value");

  a_wrap_reload: assert property (
    tick[1] && cnt_ff[1] == CNT_TOP && !(wr && addr == OFF_CNT_VALUE[1])
    |=> cnt_ff[1] == $past(reload_ff[1]))
    else $error("overflow did not load the reload value");

  a_wrap_no_zero: assert property (
    tick[0] && cnt_ff[0] == CNT_TOP && !(wr && addr == OFF_CNT_VALUE[0])
    |-> ovf[0] ##1 cnt_ff[0] == $past(reload_ff[0]))
    else $error("wrap step lost the reload or flag");

  a_write_resume: assert property (
    wr && addr == OFF_CNT_VALUE[0]
    ##1 (tick[0] && cnt_ff[0] != CNT_TOP && !wr)
    |=> cnt_ff[0] == $past(cnt_ff[0]) + CNT_STEP)
    else $error("counter did not resume after write");

  a_nofilt_capture: assert property (
    primed_ff && !flt_en_ff && edge_sel_ff && capture_input_pin && !level_ff
    |=> cap_ff == $past(wcnt_ff) && stat_ff[IRQ_CAP])
    else $error("unfiltered edge did not capture");

  a_filter_four: assert property (
    cap_evt && flt_en_ff && edge_sel_ff
    |-> capture_input_pin && $past(capture_input_pin)
        && $past(capture_input_pin, 2) && $past(capture_input_pin, 3))
    else $error("filtered capture without four high samples");

  a_filter_sample: assert property (
    primed_ff |=> samp_ff[0] == $past(capture_input_pin))
    else $error("filter missed a cpu clock sample");

  a_fall_capture: assert property (
    cap_evt && !edge_sel_ff |-> level_ff ##1 !level_ff)
    else $error("capture with edge select zero not on falling");

  a_rise_capture: assert property (
    cap_evt && edge_sel_ff |-> !level_ff ##1 level_ff)
    else $error("capture with edge select one not on rising");

  a_stat_clear: assert property (
    rd && addr == OFF_IRQ_STAT && evt == RST_IRQ |=> stat_ff == RST_IRQ)
    else $error("status read did not clear");

  a_filter_four_lo: assert property (
    cap_evt && flt_en_ff && !edge_sel_ff
    |-> !capture_input_pin && !$past(capture_input_pin)
        && !$past(capture_input_pin, 2) && !$past(capture_input_pin, 3))
    else $error("filtered capture without four low samples");

  a_filter_hold: assert property (
    primed_ff && flt_en_ff && !all_hi && !all_lo
    |=> level_ff == $past(level_ff))
    else $error("filtered level moved on a short pulse");

  a_capture_keep: assert property (
    !cap_evt |=> cap_ff == $past(cap_ff))
    else $error("capture register changed without an edge");

  a_ovf_flag: assert property (
    ovf[1] |=> stat_ff[IRQ_OVF_B])
    else $error("overflow did not set its status bit");

  a_count_write: assert property (
    wr && addr == OFF_CNT_VALUE[1] |=> cnt_ff[1] == $past(wdata))
    else $error("counter write did not land");

  a_rdata_idle: assert property (
    !rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read reply");

  a_set_wins: assert property (
    rd && addr == OFF_IRQ_STAT && evt[IRQ_CAP] |=> stat_ff[IRQ_CAP])
    else $error("capture event lost to a clearing read");

endmodule // trc_timer

/* verification/trc_cap_source.sv */
/*
  Model of the outside signal that drives the capture pin.
  Assumes start is a one-cycle pulse driven just after a rising mclk edge.
*/
`timescale 1ns/1ps
module trc_cap_source (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic       lvl,
  input  wire logic [3:0] width,
  output logic            capture_input_pin
);
  logic [3:0] left_ff;

  // new level held for width samples, then back; width 0 holds it
  // shorter than four samples only when the bench asks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      capture_input_pin <= 1'b0;
      left_ff           <= 4'h0;
    end else if (start) begin
      capture_input_pin <= lvl;
      left_ff           <= width;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
      if (left_ff == 4'h1) begin
        capture_input_pin <= ~capture_input_pin;
      end
    end
  end
endmodule // trc_cap_source

/* verification/timer_reload_and_input_capture_bench.sv */
/*
  Self-checking bench for the timer block: registers, reload, irq, capture.
  Assumes trc_timer, trc_pkg and the capture source model are compiled.
*/
`timescale 1ns/1ps
module timer_reload_and_input_capture_bench import trc_pkg::*;;
  logic         mclk;
  logic         rst_b;
  trc_bus_req_s req;
  logic [7:0]   reg_rdata;
  logic         cap_pin;
  logic         irq;
  logic [1:0]   cnt_pin;
  logic         start;
  logic         lvl;
  logic [3:0]   width;
  logic [31:0]  seed;
  logic [7:0]   d;
  logic [7:0]   r;
  int           mismatches;
  int           samples_checked;
  int           cycles = 0;
  localparam int CYCLE_LIMIT = 3000;
  // ctrl, pin level, flag expected, width
  logic [15:0]  caps [8] = '{16'h4191, 16'h0180, 16'h0110, 16'hC183,
                             16'hC194, 16'h8180, 16'h8103, 16'h8114};

  trc_timer u_trc_timer (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .reg_req           (req),
    .reg_rdata         (reg_rdata),
    .capture_input_pin (cap_pin),
    .count_a_pin       (cnt_pin[0]),
    .count_b_pin       (cnt_pin[1]),
    .irq               (irq)
  );

  trc_cap_source u_trc_cap_source (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .start             (start),
    .lvl               (lvl),
    .width             (width),
    .capture_input_pin (cap_pin)
  );

  always #2 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // counter value after n ticks, reloading instead of wrapping
  function automatic logic [7:0] after_ticks(input logic [7:0] v,
                                             input logic [7:0] rl,
                                             input int n);
    for (int k = 0; k < n; k++) begin
      v = (v == CNT_TOP) ? rl : v + CNT_STEP;
    end
    return v;
  endfunction

  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic pulse(input logic lv, input logic [3:0] wd);
    start <= 1'b1;
    lvl   <= lv;
    width <= wd;
    @(posedge mclk);
    start <= 1'b0;
  endtask

  // pin edge is seen five edges after the wide count is sampled
  task automatic cap_value(input logic [7:0] ctrl, input logic lv);
    logic [15:0] w;
    wr(OFF_WIDE_CTRL, ctrl);
    rd(OFF_IRQ_STAT, d);
    rd(OFF_WCNT_LO, w[7:0]);
    rd(OFF_WCNT_HI, w[15:8]);
    pulse(lv, 4'h0);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    w = w + 16'h0005;
    rd(OFF_CAP_LO, d);
    chk(d, w[7:0]);
    rd(OFF_CAP_HI, d);
    chk(d, w[15:8]);
    rd(OFF_IRQ_STAT, d);
    chk(d, 8'h04);
    chk({7'h00, irq}, 8'h00);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
  end

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    req = '0;
    cnt_pin = 2'h0;
    start = 1'b0;
    lvl = 1'b0;
    width = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    seed = 32'd18857;
    fork
      run_tests();
      begin
        wait (cycles >= CYCLE_LIMIT);
        mismatches++;
      end
    join_any
    finish_test();
  end

  task automatic run_tests;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(OFF_CNT_RELOAD[1], d);
    chk(d, RST_RELOAD);
    rd(8'h00, d);
    chk(d, 8'h00);
    wr(OFF_WIDE_CTRL, 8'hFF);
    rd(OFF_WIDE_CTRL, d);
    chk(d, 8'hC7); // fields
    repeat (4) begin
      seed = xs(seed);
      wr(OFF_CNT_RELOAD[1], seed[7:0]);
      rd(OFF_CNT_RELOAD[1], d);
      chk(d, seed[7:0]);
    end
    // overflow reload on both counters, external rising ticks
    wr(OFF_IRQ_MASK, 8'h03);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      r = (i == 1) ? 8'hFF : seed[7:0];
      wr(OFF_CNT_CTRL[i], {5'h00, CS_EXT_RISE});
      wr(OFF_CNT_RELOAD[i], r);
      wr(OFF_CNT_VALUE[i], 8'hFE);
      rd(OFF_IRQ_STAT, d);
      repeat (3) begin
        cnt_pin[i] <= 1'b1;
        cyc(3);
        cnt_pin[i] <= 1'b0;
        cyc(4);
      end
      rd(OFF_CNT_VALUE[i], d);
      chk(d, after_ticks(8'hFE, r, 3));
      chk({7'h00, irq}, 8'h01);
      rd(OFF_IRQ_STAT, d);
      chk(d, 8'h01 << i); // overflow flag
      chk({7'h00, irq}, 8'h00);
    end
    // running counter resumes one tick after a software write
    seed = xs(seed);
    wr(OFF_CNT_CTRL[0], {5'h00, CS_DIV1});
    wr(OFF_CNT_RELOAD[0], seed[15:8]);
    wr(OFF_CNT_VALUE[0], seed[7:0]);
    rd(OFF_CNT_VALUE[0], d);
    chk(d, after_ticks(seed[7:0], seed[15:8], 1));
    wr(OFF_CNT_CTRL[0], {5'h00, CS_STOP});
    // capture cases with the interrupt masked off
    wr(OFF_IRQ_MASK, 8'h00);
    foreach (caps[k]) begin
      wr(OFF_WIDE_CTRL, caps[k][15:8]);
      rd(OFF_IRQ_STAT, d);
      pulse(caps[k][7], caps[k][3:0]);
      cyc(10);
      chk({7'h00, irq}, 8'h00);
      rd(OFF_IRQ_STAT, d);
      chk(d, {5'h00, caps[k][4], 2'h0});
    end
    // capture value and capture interrupt, falling then rising
    wr(OFF_IRQ_MASK, 8'h04);
    cap_value(8'h01, 1'b0);
    cap_value(8'h41, 1'b1);
  endtask
endmodule // timer_reload_and_input_capture_bench
